// ==== src/engine_port_map.svh ====
// reset values and timing counts of the engine host port
`ifndef ENGINE_PORT_MAP_SVH
`define ENGINE_PORT_MAP_SVH

// clock period of the engine logic, 100 MHz
`define ENG_CLK_PERIOD_NS 10
// internal power-on hold time of the engine
`define ENG_POR_TIME_NS 20000
// least time rounds up to whole cycles
`define ENG_POR_CYCLES ((`ENG_POR_TIME_NS + `ENG_CLK_PERIOD_NS - 1) / `ENG_CLK_PERIOD_NS)
// clocks per serial bit
`define ENG_BAUD_DIV 868
// data bits per serial character
`define ENG_DATA_BITS 8
// words held between the engine and its transmitter
`define ENG_FIFO_DEPTH 4
// idle level of the serial lines in true polarity
`define ENG_LINE_IDLE 1'b1
// reset value of the reset synchroniser, the deasserted level
`define ENG_RESET_IDLE 1'b1

`endif

// ==== src/engine_port_pkg.sv ====
// types shared by the engine host port
package engine_port_pkg;
   typedef enum logic [1:0] {ENG_POR, ENG_RUN, ENG_HALT, ENG_OFF} engine_state_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage : engine_port_pkg

// ==== src/word_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("word_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // ready is registered so the top port comes from a flop
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   assign out_valid  = (count != '0);
   assign out_data   = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (reset || flush) begin
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         count    <= '0;
         in_ready <= 1'b0;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count    <= next_count;
         in_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end
endmodule : word_fifo

// ==== src/serial_tx.sv ====
// serial transmitter, start bit, data lsb first, one stop bit
`timescale 1ns/100ps
`include "engine_port_map.svh"
module serial_tx #(
   parameter int BAUD_DIV  = 868,
   parameter int DATA_BITS = 8
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic [DATA_BITS-1:0] data,
   input  wire logic                 valid,
   input  wire logic                 allow,
   output logic                      ready,
   output logic                      start,
   output logic                      line
);
   if (BAUD_DIV < 2 || BAUD_DIV > 65535 || DATA_BITS < 5 || DATA_BITS > 9) begin : g_bad
      $error("serial_tx parameters out of range");
   end

   logic [DATA_BITS+1:0] shift;
   logic [3:0]           bits;
   logic [15:0]          baud;
   logic                 busy;

   // a character starts only between frames, so a stall never cuts one
   assign ready = !busy && allow;
   assign start = valid && ready;

   always_ff @(posedge clk) begin
      if (reset) begin
         shift <= '1;
         bits  <= 4'h0;
         baud  <= 16'h0;
         busy  <= 1'b0;
         line  <= `ENG_LINE_IDLE;
      end else if (start) begin
         shift <= {1'b1, data, 1'b0};
         line  <= 1'b0;
         bits  <= 4'(DATA_BITS + 1);
         baud  <= 16'(BAUD_DIV - 1);
         busy  <= 1'b1;
      end else if (busy) begin
         if (baud != 16'h0) begin
            baud <= baud - 16'h1;
         end else if (bits == 4'h0) begin
            busy <= 1'b0;
         end else begin
            line  <= shift[1];
            shift <= {1'b1, shift[DATA_BITS+1:1]};
            bits  <= bits - 4'h1;
            baud  <= 16'(BAUD_DIV - 1);
         end
      end
   end
endmodule : serial_tx

// ==== src/engine_host_port.sv ====
// engine emergency reset and eight-line serial port facing the host
//
// Notes on behaviour
// - low reset input halts engine, stops work
// - release leaves engine off, no detach
// - engine runs own power-on sequence
// - reset input reads deasserted when unconnected
// - port carries all eight serial signals
// - engine sends on txd, receives rxd
// - lines cross: host tx to engine rx
// - engine drives carrier, ready, ring status
// - host terminal-ready input gates engine transmit
// - rts in, cts out flow control
// - true polarity, idle high lines
`timescale 1ns/100ps
`include "engine_port_map.svh"
module engine_host_port #(
   parameter int BAUD_DIV   = `ENG_BAUD_DIV,
   parameter int DATA_BITS  = `ENG_DATA_BITS,
   parameter int FIFO_DEPTH = `ENG_FIFO_DEPTH,
   parameter int POR_CYCLES = `ENG_POR_CYCLES
) (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          engine_reset_n,
   input  wire logic                          engine_power_toggle_n,
   input  wire logic                          shutdown_command,
   input  wire logic                          rxd,
   input  wire logic                          dtr,
   input  wire logic                          rts,
   output logic                               txd,
   output logic                               dcd,
   output logic                               dsr,
   output logic                               cts,
   output logic                               ring_indicate_out,
   input  wire logic                          carrier_present,
   input  wire logic                          incoming_call,
   input  wire logic [DATA_BITS-1:0]          tx_data,
   input  wire logic                          tx_valid,
   output logic                               tx_ready,
   output logic [DATA_BITS-1:0]               rx_data,
   output logic                               rx_valid,
   output logic                               rx_frame_error,
   input  wire logic                          rx_accept,
   output logic                               terminal_ready,
   output logic                               detach_request,
   output logic                               engine_in_reset,
   output engine_port_pkg::engine_state_e     engine_state
);
   import engine_port_pkg::*;

   if (BAUD_DIV < 4 || BAUD_DIV > 65535 || POR_CYCLES < 1 || POR_CYCLES > 65535) begin : g_bad
      $error("engine_host_port timing parameters out of range");
   end

   engine_state_e    state;
   engine_state_e    next_state;
   logic [15:0]      por_cnt;
   logic             rst_s1;
   logic             rst_s2;
   logic             rst_s3;
   logic             toggle_prev;
   rx_state_e        rx_state;
   logic [15:0]      rx_baud;
   logic [3:0]       rx_bits;
   logic [DATA_BITS-1:0] rx_shift;
   logic [DATA_BITS-1:0] fifo_data;
   logic             fifo_valid;
   logic             fifo_ready;
   logic             tx_start;
   logic             txd_line;

   // reset request needs two consecutive low samples past the synchroniser
   wire rst_req     = !rst_s2 && !rst_s3;
   wire running     = (state == ENG_RUN);
   wire toggle_fell = toggle_prev && !engine_power_toggle_n;
   wire por_done    = (por_cnt == 16'(POR_CYCLES - 1));
   wire off_request = shutdown_command || toggle_fell;
   // transmit waits on host readiness and host flow control
   wire tx_allow    = running && rts && dtr;
   wire tx_abort    = reset || !running;
   wire rx_tick     = (rx_baud == 16'h0);

   // synchroniser presets to the pulled-up level, so an open pin never resets
   always_ff @(posedge clk) begin
      if (reset) begin
         rst_s1 <= `ENG_RESET_IDLE;
         rst_s2 <= `ENG_RESET_IDLE;
         rst_s3 <= `ENG_RESET_IDLE;
         toggle_prev <= 1'b1;
      end else begin
         rst_s1 <= engine_reset_n;
         rst_s2 <= rst_s1;
         rst_s3 <= rst_s2;
         toggle_prev <= engine_power_toggle_n;
      end
   end

   // engine life cycle; reset wins over every other request
   always_comb begin
      next_state = state;
      unique case (state)
         ENG_POR: begin
            if (rst_req) next_state = ENG_HALT;
            else if (por_done) next_state = ENG_RUN;
         end
         ENG_RUN: begin
            if (rst_req) next_state = ENG_HALT;
            else if (off_request) next_state = ENG_OFF;
         end
         ENG_HALT: begin
            if (!rst_req) next_state = ENG_OFF;
         end
         ENG_OFF: begin
            if (rst_req) next_state = ENG_HALT;
            else if (toggle_fell) next_state = ENG_POR;
         end
      endcase
   end

   // power-on sequence is timed internally, host need not touch the pin
   always_ff @(posedge clk) begin
      if (reset) begin
         state   <= ENG_POR;
         por_cnt <= 16'h0;
      end else begin
         state   <= next_state;
         por_cnt <= (state == ENG_POR && !por_done) ? por_cnt + 16'h1 : 16'h0;
      end
   end

   // a clean shutdown detaches; the reset path never does
   always_ff @(posedge clk) begin
      if (reset) begin
         detach_request  <= 1'b0;
         engine_in_reset <= 1'b1;
         engine_state    <= ENG_POR;
      end else begin
         detach_request  <= running && !rst_req && off_request;
         engine_in_reset <= (next_state == ENG_HALT) || (next_state == ENG_POR);
         engine_state    <= next_state;
      end
   end

   // modem status lines, true polarity; all but terminal_ready held low unless running
   always_ff @(posedge clk) begin
      if (reset) begin
         dcd               <= 1'b0;
         dsr               <= 1'b0;
         ring_indicate_out <= 1'b0;
         cts               <= 1'b0;
         terminal_ready    <= 1'b0;
      end else begin
         dcd               <= running && carrier_present;
         dsr               <= running;
         ring_indicate_out <= running && incoming_call;
         cts               <= running && rx_accept;
         terminal_ready    <= dtr;
      end
   end

   // receiver on the host's transmit line, sampled mid-bit
   always_ff @(posedge clk) begin
      if (reset || !running) begin
         rx_state       <= RX_IDLE;
         rx_baud        <= 16'h0;
         rx_bits        <= 4'h0;
         rx_shift       <= '0;
         rx_data        <= '0;
         rx_valid       <= 1'b0;
         rx_frame_error <= 1'b0;
      end else begin
         rx_valid       <= 1'b0;
         rx_frame_error <= 1'b0;
         // bit timer counts down on its own, every state but stop reloads it
         if (!rx_tick) rx_baud <= rx_baud - 16'h1;
         unique case (rx_state)
            RX_IDLE: begin
               if (rxd != `ENG_LINE_IDLE) begin
                  rx_state <= RX_START;
                  rx_baud  <= 16'(BAUD_DIV / 2 - 1);
               end
            end
            RX_START: begin
               if (rx_tick) begin
                  // a glitch shorter than half a bit is dropped here
                  rx_state <= rxd ? RX_IDLE : RX_DATA;
                  rx_baud  <= 16'(BAUD_DIV - 1);
                  rx_bits  <= 4'(DATA_BITS);
               end
            end
            RX_DATA: begin
               if (rx_tick) begin
                  rx_shift <= {rxd, rx_shift[DATA_BITS-1:1]};
                  rx_baud  <= 16'(BAUD_DIV - 1);
                  rx_bits  <= rx_bits - 4'h1;
                  if (rx_bits == 4'h1) rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_tick) begin
                  rx_state       <= RX_IDLE;
                  rx_data        <= rx_shift;
                  rx_valid       <= rxd;
                  rx_frame_error <= !rxd;
               end
            end
         endcase
      end
   end

   // fifo absorbs bursts while the host holds rts low
   word_fifo #(
      .WIDTH (DATA_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .reset     (reset),
      .flush     (!running),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   // transmitter drives the host's receive line
   serial_tx #(
      .BAUD_DIV  (BAUD_DIV),
      .DATA_BITS (DATA_BITS)
   ) u_tx (
      .clk   (clk),
      .reset (tx_abort),
      .data  (fifo_data),
      .valid (fifo_valid),
      .allow (tx_allow),
      .ready (fifo_ready),
      .start (tx_start),
      .line  (txd_line)
   );

   assign txd = txd_line;

   // checks run on the engine clock and, except AST_IDLE_AFTER_RESET, rest while the block is in reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_HALT_ON_LOW: assert property (rst_req |=> state == ENG_HALT)
      else $error("engine not halted while reset request held");
   AST_OFF_NO_DETACH: assert property (
      state == ENG_HALT && !rst_req |=> state == ENG_OFF && !detach_request)
      else $error("reset release did not leave engine off without detach");
   AST_POR_TO_RUN: assert property (
      state == ENG_POR && !rst_req && por_done |=> state == ENG_RUN)
      else $error("power-on sequence did not reach run");
   AST_TWO_LOW_SAMPLES: assert property (
      rst_req |-> !$past(engine_reset_n, 2) && !$past(engine_reset_n, 3))
      else $error("reset request without two low samples");
   AST_IDLE_AFTER_RESET: assert property (disable iff (1'b0)
      $past(reset) |-> !rst_req)
      else $error("reset request right after reset");
   AST_DSR_TRACKS_RUN: assert property (dsr == $past(running))
      else $error("dsr does not follow engine run state");
   AST_CTS_ONLY_RUN: assert property (cts |-> $past(running) && $past(rx_accept))
      else $error("cts raised while engine cannot accept");
   AST_TX_GATED: assert property (tx_start |-> rts && dtr && running)
      else $error("character started without rts and dtr");
   AST_TXD_IDLE_HALT: assert property ((state == ENG_HALT) [*2] |-> txd)
      else $error("txd not idle high while halted");
   AST_RX_ONLY_RUN: assert property (rx_valid |-> $past(running))
      else $error("received byte while engine not running");
   // outputs other than terminal_ready, engine_in_reset and engine_state stay quiet outside a clean run, detach only on clean shutdown
   AST_DETACH_CLEAN: assert property (
      detach_request |-> $past(state == ENG_RUN) && !$past(rst_req))
      else $error("detach pulse without a clean shutdown from run");
   AST_STATUS_QUIET_HALT: assert property (
      $past(state == ENG_HALT) |-> !dsr && !dcd && !cts && !ring_indicate_out)
      else $error("status line active while engine held in reset");
   AST_TXD_IDLE_OFF: assert property ((state == ENG_OFF) [*2] |-> txd)
      else $error("txd not idle high while engine off");
   AST_DTR_FOLLOWED: assert property (!$past(reset) |-> terminal_ready == $past(dtr))
      else $error("terminal_ready does not follow dtr");
   AST_STATUS_ONLY_RUN: assert property (
      dcd || ring_indicate_out |-> $past(running))
      else $error("carrier or ring raised while engine not running");
   AST_TX_READY_RUN: assert property (tx_ready |-> $past(running))
      else $error("transmit ready raised while engine not running");

   // scenarios worth seeing at least once
   COV_POR_RUN: cover property (state == ENG_POR ##1 state == ENG_RUN);
   COV_HALT_OFF: cover property (state == ENG_HALT ##1 state == ENG_OFF);
   COV_RX_BYTE: cover property (rx_valid);
   COV_TX_STALL: cover property (fifo_valid && !rts ##1 !tx_ready);
   COV_RESET_MID_FRAME: cover property (rst_req && tx_allow && !fifo_ready);
endmodule : engine_host_port

// ==== verification/host_model.sv ====
// host processor model: open-collector reset driver and host serial port
`timescale 1ns/100ps
module host_model #(
   parameter int BAUD_DIV = 8
) (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd,
   output logic      engine_reset_n
);
   logic       pull_low;
   logic [7:0] rx_q[$];

   // transistor only sinks; a released pin floats up to the pull-up
   assign engine_reset_n = pull_low ? 1'b0 : 1'b1;

   initial begin
      pull_low = 1'b0;
      rxd      = 1'b1;
   end

   // host transmit feeds engine receive, true polarity, lsb first
   task automatic send(input logic [7:0] b, input logic stop_bit);
      int i;
      rxd = 1'b0;
      repeat (BAUD_DIV) @(negedge clk);
      for (i = 0; i < 8; i++) begin
         rxd = b[i];
         repeat (BAUD_DIV) @(negedge clk);
      end
      rxd = stop_bit;
      repeat (BAUD_DIV) @(negedge clk);
      rxd = 1'b1;
      repeat (BAUD_DIV) @(negedge clk);
   endtask : send

   // host receive samples the engine transmit line mid-bit
   always begin : host_rx
      logic [7:0] b;
      int         i;
      @(negedge txd);
      repeat (BAUD_DIV / 2) @(posedge clk);
      if (txd === 1'b0) begin
         for (i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge clk);
            b[i] = txd;
         end
         repeat (BAUD_DIV) @(posedge clk);
         if (txd === 1'b1) rx_q.push_back(b);
      end
   end
endmodule : host_model

// ==== verification/gsm_engine_uart_reset_port_bench.sv ====
// bench for the engine host port: reference queues against the design
`timescale 1ns/100ps
module gsm_engine_uart_reset_port_bench;
   import engine_port_pkg::*;
   localparam int BD  = 8;
   localparam int POR = 5;
   logic          clk;
   logic          reset;
   logic          engine_reset_n;
   logic          engine_power_toggle_n;
   logic          shutdown_command;
   logic          rxd;
   logic          dtr;
   logic          rts;
   logic          txd;
   logic          dcd;
   logic          dsr;
   logic          cts;
   logic          ring_indicate_out;
   logic          carrier_present;
   logic          incoming_call;
   logic [7:0]    tx_data;
   logic          tx_valid;
   logic          tx_ready;
   logic [7:0]    rx_data;
   logic          rx_valid;
   logic          rx_frame_error;
   logic          rx_accept;
   logic          terminal_ready;
   logic          detach_request;
   logic          engine_in_reset;
   engine_state_e engine_state;
   int            n_mismatch = 0;
   int            n_compared = 0;
   int            n_detach   = 0;
   int            n_ferr     = 0;
   logic [7:0]    exp_q[$];
   logic [7:0]    got_q[$];

   engine_host_port #(.BAUD_DIV(BD), .DATA_BITS(8), .FIFO_DEPTH(4), .POR_CYCLES(POR)) dut (
      .clk(clk), .reset(reset), .engine_reset_n(engine_reset_n),
      .engine_power_toggle_n(engine_power_toggle_n), .shutdown_command(shutdown_command),
      .rxd(rxd), .dtr(dtr), .rts(rts), .txd(txd), .dcd(dcd), .dsr(dsr), .cts(cts),
      .ring_indicate_out(ring_indicate_out), .carrier_present(carrier_present),
      .incoming_call(incoming_call), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_frame_error(rx_frame_error), .rx_accept(rx_accept),
      .terminal_ready(terminal_ready), .detach_request(detach_request),
      .engine_in_reset(engine_in_reset), .engine_state(engine_state));

   host_model #(.BAUD_DIV(BD)) host (
      .clk(clk), .txd(txd), .rxd(rxd), .engine_reset_n(engine_reset_n));

   always #5 clk = ~clk;

   // one-cycle pulses are sampled at the falling edge, clear of update races
   always @(negedge clk) begin
      if (rx_valid === 1'b1) got_q.push_back(rx_data);
      if (rx_frame_error === 1'b1) n_ferr++;
      if (detach_request === 1'b1) n_detach++;
   end

   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
         n_mismatch++;
      end
   endtask : check

   task automatic timeout(input string what);
      $display("[FAIL] %s expected done seen timeout", what);
      n_mismatch++;
      close_out();
   endtask : timeout

   task automatic wait_state(input engine_state_e s, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         if (engine_state === s) return;
         @(negedge clk);
      end
      timeout("engine_state");
   endtask : wait_state

   // src 0 is the host receive queue, 1 the engine receive queue
   task automatic wait_for(input int src, input int want);
      int i;
      for (i = 0; i < 200 * BD; i++) begin
         if ((src == 0 ? host.rx_q.size() : got_q.size()) >= want) return;
         @(negedge clk);
      end
      timeout("byte queue");
   endtask : wait_for

   task automatic cmp_q(input string what, input logic [7:0] got[$]);
      int i;
      check({what, " count"}, exp_q.size(), got.size());
      for (i = 0; i < exp_q.size() && i < got.size(); i++) check(what, exp_q[i], got[i]);
      exp_q.delete();
   endtask : cmp_q

   // power toggle acts on its falling edge
   task automatic toggle();
      engine_power_toggle_n = 1'b0;
      @(negedge clk);
      engine_power_toggle_n = 1'b1;
   endtask : toggle

   initial begin
      int          i;
      logic [7:0]  b;
      logic [31:0] r;
      void'($urandom(45933));
      clk = 1'b0;
      reset = 1'b1;
      engine_power_toggle_n = 1'b1;
      shutdown_command = 1'b0;
      {dtr, rts, carrier_present, incoming_call, rx_accept, tx_valid} = '0;
      tx_data = 8'h00;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      check("state after reset", ENG_POR, engine_state);
      check("engine_in_reset", 1, engine_in_reset);
      wait_state(ENG_RUN, POR + 10);
      // status outputs follow their causes while running
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         {rx_accept, dtr, incoming_call, carrier_present} = r[3:0];
         repeat (3) @(negedge clk);
         check("dcd", r[0], dcd);
         check("ring_indicate_out", r[1], ring_indicate_out);
         check("terminal_ready", r[2], terminal_ready);
         check("cts", r[3], cts);
         check("dsr", 1, dsr);
      end
      // host stalls with rts low until the fifo refuses, then drains
      dtr = 1'b1;
      rts = 1'b0;
      for (i = 0; i < 7; i++) begin
         b = 8'($urandom);
         tx_data = b;
         tx_valid = 1'b1;
         if (tx_ready === 1'b1) exp_q.push_back(b);
         @(negedge clk);
      end
      tx_valid = 1'b0;
      check("tx_ready when full", 0, tx_ready);
      check("txd during stall", 1, txd);
      check("bytes held", 4, exp_q.size());
      rts = 1'b1;
      wait_for(0, exp_q.size());
      cmp_q("host rx byte", host.rx_q);
      host.rx_q.delete();
      // minimal host: data lines only, handshake inputs low
      dtr = 1'b0;
      rts = 1'b0;
      for (i = 0; i < 4; i++) begin
         b = 8'($urandom);
         exp_q.push_back(b);
         host.send(b, 1'b1);
      end
      wait_for(1, 4);
      cmp_q("rx_data", got_q);
      got_q.delete();
      host.send(8'hA5, 1'b0);
      repeat (2 * BD) @(negedge clk);
      check("frame errors", 1, n_ferr);
      // clean shutdown by command and by toggle, each with one detach
      shutdown_command = 1'b1;
      @(negedge clk);
      shutdown_command = 1'b0;
      wait_state(ENG_OFF, 8);
      repeat (2) @(negedge clk);
      check("detach after command", 1, n_detach);
      check("dsr when off", 0, dsr);
      toggle();
      wait_state(ENG_RUN, POR + 10);
      toggle();
      wait_state(ENG_OFF, 8);
      repeat (2) @(negedge clk);
      check("detach after toggle", 2, n_detach);
      toggle();
      wait_state(ENG_RUN, POR + 10);
      // a single low sample must not reset the engine
      host.pull_low = 1'b1;
      @(negedge clk);
      host.pull_low = 1'b0;
      repeat (6) @(negedge clk);
      check("glitch ignored", ENG_RUN, engine_state);
      // emergency reset in mid-frame halts, release leaves it off, no detach
      {dtr, rts} = 2'b11;
      tx_data = 8'h0F;
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      repeat (3 * BD) @(negedge clk);
      host.pull_low = 1'b1;
      wait_state(ENG_HALT, 8);
      repeat (2) @(negedge clk);
      check("engine_in_reset halt", 1, engine_in_reset);
      check("dsr halt", 0, dsr);
      check("txd aborted", 1, txd);
      repeat (10) @(negedge clk);
      host.pull_low = 1'b0;
      wait_state(ENG_OFF, 8);
      repeat (20) @(negedge clk);
      check("stays off", ENG_OFF, engine_state);
      check("no detach on reset", 2, n_detach);
      close_out();
   end

   // guard against a hang anywhere in the run
   initial begin
      repeat (100000) @(posedge clk);
      timeout("whole run");
   end
endmodule : gsm_engine_uart_reset_port_bench
